/* File: core/oarc_chan.v */
// One channel divider with preset hold and coarse phase offset.
// Assumes hold and cfg come from clk-domain logic of the parent.
`timescale 1ns/100ps
`include "oarc_defines.vh"
module oarc_chan (
  input wire clk,
  input wire rst_n,
  input wire hold,
  input wire chan_pd,
  input wire [3:0] low_cyc,
  input wire [3:0] high_cyc,
  input wire start_high,
  input wire [3:0] phase_off,
  output reg div_out
);
  localparam ST_HOLD = 4'b0001;
  localparam ST_DLY = 4'b0010;
  localparam ST_HI = 4'b0100;
  localparam ST_LO = 4'b1000;

  reg [3:0] st_q;
  reg [4:0] cnt_q;
  wire [4:0] phase_code;
  wire [4:0] dly;

  assign phase_code = {start_high, phase_off};
  // Big codes wrap through the low phase
  assign dly = (phase_code < `OARC_PHS_BIG) ? phase_code :
               ({1'b0, phase_off} + {1'b0, low_cyc} + 5'h01); // [R22]

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_HOLD;
      cnt_q <= 5'h00;
      div_out <= 1'b0;
    end else if (chan_pd) begin
      st_q <= ST_HOLD;
      cnt_q <= 5'h00;
      div_out <= 1'b0;
    end else if (hold) begin
      st_q <= ST_HOLD;
      cnt_q <= 5'h00;
      div_out <= start_high; // [R9]
    end else begin
      case (st_q)
        ST_HOLD: begin
          if (dly == 5'h00) begin
            st_q <= ST_HI;
            cnt_q <= {1'b0, high_cyc};
            div_out <= 1'b1;
          end else begin
            st_q <= ST_DLY; // [R9]
            cnt_q <= dly - 5'h01;
          end
        end
        ST_DLY: begin
          if (cnt_q == 5'h00) begin
            st_q <= ST_HI;
            cnt_q <= {1'b0, high_cyc};
            div_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        ST_HI: begin
          if (cnt_q == 5'h00) begin
            st_q <= ST_LO;
            cnt_q <= {1'b0, low_cyc};
            div_out <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        ST_LO: begin
          if (cnt_q == 5'h00) begin
            st_q <= ST_HI;
            cnt_q <= {1'b0, high_cyc};
            div_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        default: begin
          st_q <= ST_HOLD;
          cnt_q <= 5'h00;
          div_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: core/oarc_defines.vh */
// Constants for the output alignment and reset control block.
// Assumes a 200 MHz channel-divider input clock and an APB register port.
//
// Operation
// [R1] Low then high on sync pin starts an alignment; outputs resume preset.
// [R2] Set then clear of soft sync, soft reset or distribution power-down aligns.
// [R3] Chip reset pin low then high also aligns the outputs.
// [R4] Power-down pin low then high also aligns the outputs.
// [R5] VCO calibration holds an alignment request until it completes.
// [R6] Asynchronous sync pin gives up to one input-clock cycle of uncertainty.
// [R7] Output clocking restarts a fixed pipeline of cycles after request rises; the pipeline count here starts when the request clears.
// [R8] Software issues an update after setting and after clearing soft sync.
// [R9] Included channels hold level from start-high, resume with set phase.
// [R10] Channels marked ignore keep toggling and are not aligned.
// [R11] Channel alignment applies to all three drivers the channel feeds.
// [R12] Each differential output has swing, polarity and power-down control.
// [R13] Distribution power-down bit shuts off all differential drivers together.
// [R14] Safe power-down from driver bit, channel power-down or sleep.
// [R15] Selecting single-ended mode turns on A and B; each separately set.
// [R16] Two-bit enable field powers down single-ended drivers, which tristate.
// [R17] Power-on reset loads settings, aligns, outputs start about 70 ms later.
// [R18] Reset pin pulse restores settings; outputs after 2 us or 20 ms.
// [R19] Both soft reset bits restore all but port register, self-clear.
// [R20] Reload bit with config pin high reloads stored settings, 20 ms.
// [R21] New phase offset needs an alignment before it takes effect.
// [R22] Phase code 16*start-high+offset; above 15 adds low count plus one.
// [R23] All triggers merge into one request, released via two-stage synchronizer.
////////////////////////////////////////////////////////////////////////////////
`ifndef OARC_DEFINES_VH
`define OARC_DEFINES_VH

// Register indices; byte address is four times the index
`define OARC_IDX_PORT 12'h000
`define OARC_IDX_OUT0 12'h0F0
`define OARC_IDX_OUTN 12'h0FB
`define OARC_IDX_DIV0 12'h190
`define OARC_IDX_DIVN 12'h19B
`define OARC_IDX_SYNC 12'h230
`define OARC_IDX_UPD 12'h232
`define OARC_IDX_STAT 12'h233
`define OARC_IDX_EE 12'hB02

// Field positions
`define OARC_PORT_SRST_A 2
`define OARC_PORT_SRST_B 5
`define OARC_SYNC_SOFT 0
`define OARC_SYNC_DPD 1
`define OARC_UPD_ALL 0
`define OARC_EE_RELOAD 1
`define OARC_OUT_PD 0
`define OARC_OUT_SW_LO 1
`define OARC_OUT_SW_HI 2
`define OARC_OUT_POL_A 3
`define OARC_OUT_POL_B 4
`define OARC_OUT_EN_A 5
`define OARC_OUT_EN_B 6
`define OARC_OUT_CMOS 7
`define OARC_PHS_SH 4
`define OARC_PHS_IGN 5
`define OARC_CHPD_BIT 2

// Reset values
`define OARC_PORT_RST 8'h00
`define OARC_OUT_RST 8'h00
`define OARC_DIV_RST 8'h00
`define OARC_PHS_RST 8'h00
`define OARC_CHPD_RST 8'h00
`define OARC_SYNC_RST 2'h0

// Timing
`define OARC_CLK_KHZ 200000
`define OARC_POR_MS 70
`define OARC_EE_MS 20
`define OARC_DEF_US 2
`define OARC_POR_CYC (`OARC_POR_MS * `OARC_CLK_KHZ)
`define OARC_EE_CYC (`OARC_EE_MS * `OARC_CLK_KHZ)
`define OARC_DEF_CYC (`OARC_DEF_US * `OARC_CLK_KHZ / 1000)
`define OARC_SYNC_PIPE 4'hE
`define OARC_LD_W 24
`define OARC_PHS_BIG 5'h10

`endif

/* File: core/oarc_sync2.v */
// Two-flop synchroniser for pin levels.
// Assumes inputs asynchronous to clk; reset value per bit is a parameter.
`timescale 1ns/100ps
module oarc_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: core/oarc_top.v */
// Output alignment, reset sequencing and driver control, with APB registers.
// Assumes clk is the channel-divider input clock; pins are asynchronous.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "oarc_defines.vh"
module oarc_top #(
  parameter [23:0] POR_CYC = `OARC_POR_CYC,
  parameter [23:0] EE_CYC = `OARC_EE_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire [13:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sync_n,
  input wire chip_reset_n,
  input wire power_down_pin_n,
  input wire cfg_sel,
  input wire vco_cal_busy,
  output reg [11:0] drv_p,
  output reg [11:0] drv_n,
  output reg [23:0] drv_swing,
  output reg [11:0] drv_safe_pd,
  output reg drv_total_pd,
  output reg [11:0] cmos_a,
  output reg [11:0] cmos_a_oe_n,
  output reg [11:0] cmos_b,
  output reg [11:0] cmos_b_oe_n,
  output reg align_active
);
  localparam [3:0] K_NONE = 4'h0;
  localparam [3:0] K_PORT = 4'h1;
  localparam [3:0] K_OUT = 4'h2;
  localparam [3:0] K_CHAN = 4'h3;
  localparam [3:0] K_SYNC = 4'h4;
  localparam [3:0] K_UPD = 4'h5;
  localparam [3:0] K_STAT = 4'h6;
  localparam [3:0] K_EE = 4'h7;

  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_PIPE = 3'b100;

  localparam [23:0] DEF_CYC = `OARC_DEF_CYC;

  function [3:0] reg_kind;
    input [11:0] idx;
    begin
      if (idx == `OARC_IDX_PORT)
        reg_kind = K_PORT;
      else if (idx >= `OARC_IDX_OUT0 && idx <= `OARC_IDX_OUTN)
        reg_kind = K_OUT;
      else if (idx >= `OARC_IDX_DIV0 && idx <= `OARC_IDX_DIVN)
        reg_kind = K_CHAN;
      else if (idx == `OARC_IDX_SYNC)
        reg_kind = K_SYNC;
      else if (idx == `OARC_IDX_UPD)
        reg_kind = K_UPD;
      else if (idx == `OARC_IDX_STAT)
        reg_kind = K_STAT;
      else if (idx == `OARC_IDX_EE)
        reg_kind = K_EE;
      else
        reg_kind = K_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pins and bus decode
  wire [3:0] pins_s;
  wire sync_s;
  wire rpin_s;
  wire pdpin_s;
  wire cfg_s;
  wire [11:0] idx;
  wire [3:0] kind;
  wire [3:0] out_sel;
  wire [3:0] ch_q, ch_r;
  wire [1:0] ch_k;
  wire [1:0] ch_sub;
  wire wr;
  wire rd_setup;

  oarc_sync2 #(.WIDTH(4), .RST_VAL(4'hF)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({sync_n, chip_reset_n, power_down_pin_n, cfg_sel}),
    .q(pins_s)
  );
  assign sync_s = pins_s[3];
  assign rpin_s = pins_s[2];
  assign pdpin_s = pins_s[1];
  assign cfg_s = pins_s[0];

  assign idx = paddr[13:2];
  assign kind = reg_kind(idx);
  assign out_sel = idx[3:0];
  assign ch_q = out_sel / 4'h3;
  assign ch_r = out_sel % 4'h3;
  assign ch_k = ch_q[1:0];
  assign ch_sub = ch_r[1:0];
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (kind == K_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] port_q;
  reg [7:0] out_q [0:11];
  reg [7:0] div_q [0:3];
  reg [7:0] phs_q [0:3];
  reg [7:0] chpd_q [0:3];
  reg [1:0] sync_buf_q;
  reg [1:0] sync_act_q;
  reg rpin_d_q;
  reg [23:0] ld_cnt_q;
  reg [2:0] st_q;
  reg [3:0] pipe_q;
  wire soft_rst;
  wire reload;
  wire rpin_rise;
  wire restore;
  wire ld_busy;
  wire req_raw;
  wire req_s;
  integer i;

  assign soft_rst = wr & (kind == K_PORT) & pwdata[`OARC_PORT_SRST_A] &
                    pwdata[`OARC_PORT_SRST_B]; // [R19]
  // Reload only meaningful with stored settings selected
  assign reload = wr & (kind == K_EE) & pwdata[`OARC_EE_RELOAD] &
                  cfg_s; // [R20]
  assign rpin_rise = rpin_s & ~rpin_d_q;
  assign restore = ~rpin_s | soft_rst | reload; // [R18] [R19] [R20]
  assign ld_busy = (ld_cnt_q != 24'h000000);

  always @(posedge clk) begin
    if (!rst_n) begin
      rpin_d_q <= 1'b1;
    end else begin
      rpin_d_q <= rpin_s;
    end
  end

  always @(posedge clk) begin
    if (!rst_n || !rpin_s) begin
      port_q <= `OARC_PORT_RST;
    end else if (wr && kind == K_PORT) begin
      port_q <= pwdata[7:0];
      // Soft reset bits self-clear
      port_q[`OARC_PORT_SRST_A] <= 1'b0; // [R19]
      port_q[`OARC_PORT_SRST_B] <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_n || restore) begin
      for (i = 0; i < 12; i = i + 1)
        out_q[i] <= `OARC_OUT_RST;
      for (i = 0; i < 4; i = i + 1) begin
        div_q[i] <= `OARC_DIV_RST;
        phs_q[i] <= `OARC_PHS_RST;
        chpd_q[i] <= `OARC_CHPD_RST;
      end
      sync_buf_q <= `OARC_SYNC_RST;
      sync_act_q <= `OARC_SYNC_RST;
    end else if (wr) begin
      if (kind == K_OUT) begin
        out_q[out_sel] <= pwdata[7:0];
        // Entering single-ended mode powers both drivers up
        if (pwdata[`OARC_OUT_CMOS] && !out_q[out_sel][`OARC_OUT_CMOS]) begin
          out_q[out_sel][`OARC_OUT_EN_A] <= 1'b1; // [R15]
          out_q[out_sel][`OARC_OUT_EN_B] <= 1'b1;
        end
      end
      if (kind == K_CHAN) begin
        case (ch_sub)
          2'h0: div_q[ch_k] <= pwdata[7:0];
          2'h1: phs_q[ch_k] <= pwdata[7:0]; // [R21]
          default: chpd_q[ch_k] <= pwdata[7:0];
        endcase
      end
      if (kind == K_SYNC)
        sync_buf_q <= pwdata[1:0];
      // Soft sync and distribution power-down act only on update
      if (kind == K_UPD && pwdata[`OARC_UPD_ALL])
        sync_act_q <= sync_buf_q; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings-load wait: outputs stay static until it expires
  always @(posedge clk) begin
    if (!rst_n) begin
      ld_cnt_q <= POR_CYC; // [R17]
    end else if (!rpin_s) begin
      ld_cnt_q <= 24'h000000;
    end else if (rpin_rise || soft_rst) begin
      ld_cnt_q <= cfg_s ? EE_CYC : DEF_CYC; // [R18] [R19]
    end else if (reload) begin
      ld_cnt_q <= EE_CYC; // [R20]
    end else if (ld_busy) begin
      ld_cnt_q <= ld_cnt_q - 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alignment request and release pipeline
  assign req_raw = ~sync_s | // [R1]
                   sync_act_q[`OARC_SYNC_SOFT] |
                   sync_act_q[`OARC_SYNC_DPD] | // [R2]
                   ~rpin_s | // [R3]
                   ~pdpin_s | // [R4]
                   vco_cal_busy | // [R5]
                   ld_busy; // [R17] [R18] [R19] [R20]

  // Merged request crosses a second synchroniser; costs two cycles
  oarc_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_req_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(req_raw),
    .q(req_s)
  ); // [R23] [R6]

  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_HOLD;
      pipe_q <= 4'h0;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (req_s)
            st_q <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!req_s) begin
            st_q <= ST_PIPE;
            pipe_q <= `OARC_SYNC_PIPE - 4'h1; // [R7]
          end
        end
        ST_PIPE: begin
          if (req_s)
            st_q <= ST_HOLD;
          else if (pipe_q == 4'h0)
            st_q <= ST_RUN; // [R7]
          else
            pipe_q <= pipe_q - 4'h1;
        end
        default: begin
          st_q <= ST_HOLD;
          pipe_q <= 4'h0;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n)
      align_active <= 1'b1;
    else
      align_active <= (st_q != ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel dividers
  wire [3:0] chan_out;
  genvar g;

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      oarc_chan u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .hold((st_q != ST_RUN) & ~phs_q[g][`OARC_PHS_IGN]), // [R10]
        .chan_pd(chpd_q[g][`OARC_CHPD_BIT] | ~pdpin_s),
        .low_cyc(div_q[g][7:4]),
        .high_cyc(div_q[g][3:0]),
        .start_high(phs_q[g][`OARC_PHS_SH]),
        .phase_off(phs_q[g][3:0]),
        .div_out(chan_out[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers, three per channel
  always @(posedge clk) begin
    if (!rst_n)
      drv_total_pd <= 1'b0;
    else
      drv_total_pd <= sync_act_q[`OARC_SYNC_DPD]; // [R13]
  end

  generate
    for (g = 0; g < 12; g = g + 1) begin : g_drv
      wire src;
      wire safe;
      wire se_on;
      wire a_on;
      wire b_on;
      assign src = chan_out[g / 3]; // [R11]
      assign safe = out_q[g][`OARC_OUT_PD] |
                    chpd_q[g / 3][`OARC_CHPD_BIT] | ~pdpin_s; // [R14]
      assign se_on = out_q[g][`OARC_OUT_CMOS] &
                     ~chpd_q[g / 3][`OARC_CHPD_BIT] & pdpin_s &
                     ~sync_act_q[`OARC_SYNC_DPD];
      assign a_on = se_on & out_q[g][`OARC_OUT_EN_A]; // [R16]
      assign b_on = se_on & out_q[g][`OARC_OUT_EN_B];

      always @(posedge clk) begin
        if (!rst_n) begin
          drv_p[g] <= 1'b0;
          drv_n[g] <= 1'b0;
          drv_swing[2*g+1:2*g] <= 2'h0;
          drv_safe_pd[g] <= 1'b1;
          cmos_a[g] <= 1'b0;
          cmos_a_oe_n[g] <= 1'b1;
          cmos_b[g] <= 1'b0;
          cmos_b_oe_n[g] <= 1'b1;
        end else begin
          drv_swing[2*g+1:2*g] <=
            out_q[g][`OARC_OUT_SW_HI:`OARC_OUT_SW_LO]; // [R12]
          drv_safe_pd[g] <= safe | out_q[g][`OARC_OUT_CMOS];
          if (!safe && !out_q[g][`OARC_OUT_CMOS] &&
              !sync_act_q[`OARC_SYNC_DPD]) begin
            drv_p[g] <= src ^ out_q[g][`OARC_OUT_POL_A]; // [R12]
            drv_n[g] <= ~(src ^ out_q[g][`OARC_OUT_POL_A]);
          end else begin
            drv_p[g] <= 1'b0;
            drv_n[g] <= 1'b0;
          end
          // Powered-down single-ended drivers release the pin
          cmos_a[g] <= a_on & (src ^ out_q[g][`OARC_OUT_POL_A]); // [R15]
          cmos_a_oe_n[g] <= ~a_on; // [R16]
          cmos_b[g] <= b_on & (src ^ out_q[g][`OARC_OUT_POL_B]);
          cmos_b_oe_n[g] <= ~b_on;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in setup so it is a flop in the access phase
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (kind)
        K_PORT: prdata <= {24'h000000, port_q};
        K_OUT: prdata <= {24'h000000, out_q[out_sel]};
        K_CHAN: begin
          case (ch_sub)
            2'h0: prdata <= {24'h000000, div_q[ch_k]};
            2'h1: prdata <= {24'h000000, phs_q[ch_k]};
            default: prdata <= {24'h000000, chpd_q[ch_k]};
          endcase
        end
        K_SYNC: prdata <= {30'h00000000, sync_buf_q};
        K_STAT: prdata <= {28'h0000000, cfg_s, ~pdpin_s, ld_busy,
                           st_q != ST_RUN};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: dv/oarc_host_pins.sv */
// Host-side model of the alignment, reset, sleep and config pins.
// Assumes the bench calls drive or pulse from its main sequence.
`timescale 1ns/100ps
module oarc_host_pins (
  input wire clk,
  output reg sync_n,
  output reg chip_reset_n,
  output reg power_down_pin_n,
  output reg cfg_sel
);
  initial begin
    sync_n = 1'b1;
    chip_reset_n = 1'b1;
    power_down_pin_n = 1'b1;
    cfg_sel = 1'b0;
  end
  ////////////////////////////////////////
  // Pins move just after an edge, as a slow host would
  task drive(input int sel, input bit v);
    @(posedge clk);
    case (sel)
      0: sync_n <= v;
      1: chip_reset_n <= v;
      2: power_down_pin_n <= v;
      default: cfg_sel <= v;
    endcase
  endtask
  task pulse(input int sel, input int len);
    drive(sel, 1'b0);
    repeat (len) @(posedge clk);
    drive(sel, 1'b1);
  endtask
endmodule

/* File: dv/oarc_top_assertions.sv */
// Checker on the pins and driver outputs of oarc_top.
// Assumes the bench never overlaps two alignment triggers.
`timescale 1ns/100ps
module oarc_top_assertions (
  input wire clk,
  input wire rst_n,
  input wire sync_n,
  input wire chip_reset_n,
  input wire power_down_pin_n,
  input wire vco_cal_busy,
  input wire [11:0] drv_p,
  input wire [11:0] drv_n,
  input wire [11:0] drv_safe_pd,
  input wire drv_total_pd,
  input wire align_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire quiet = chip_reset_n && power_down_pin_n && !vco_cal_busy;
  ////////////////////////////////////////
  property p_sync_fall;
    $fell(sync_n) |-> ##[1:6] align_active;
  endproperty
  a_sync_fall: assert property (p_sync_fall)
    else $error("sync pin low did not hold outputs");
  property p_sync_hold;
    $rose(sync_n) && align_active |-> align_active [*8];
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("outputs released too early after sync");
  property p_sync_rel;
    $rose(sync_n) && quiet |-> ##[14:24] !align_active;
  endproperty
  a_sync_rel: assert property (p_sync_rel)
    else $error("outputs not released after sync");
  property p_reset_pin;
    $fell(chip_reset_n) |-> ##[1:6] align_active;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin did not hold outputs");
  property p_pd_pin;
    $fell(power_down_pin_n) |-> ##[1:6] align_active;
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("sleep pin did not hold outputs");
  property p_vco_hold;
    vco_cal_busy [*6] |-> align_active;
  endproperty
  a_vco_hold: assert property (p_vco_hold)
    else $error("calibration did not hold outputs");
  property p_vco_rel;
    $fell(vco_cal_busy) && sync_n && chip_reset_n && power_down_pin_n
      |-> ##[10:24] !align_active;
  endproperty
  a_vco_rel: assert property (p_vco_rel)
    else $error("outputs not released after calibration");
  property p_sleep_safe;
    !power_down_pin_n [*8] |-> drv_safe_pd == 12'hFFF;
  endproperty
  a_sleep_safe: assert property (p_sleep_safe)
    else $error("sleep did not put drivers in safe off");
  property p_total_off;
    drv_total_pd && $past(drv_total_pd) |-> (drv_p | drv_n) == 12'h000;
  endproperty
  a_total_off: assert property (p_total_off)
    else $error("driver active in total power-down");
  property p_safe_off;
    (drv_safe_pd & $past(drv_safe_pd) & (drv_p | drv_n)) == 12'h000;
  endproperty
  a_safe_off: assert property (p_safe_off)
    else $error("driver active in safe power-down");
  c_release: cover property ($fell(align_active));
  c_total: cover property (drv_total_pd);
  c_sleep: cover property (!power_down_pin_n [*8]);
endmodule
bind oarc_top oarc_top_assertions oarc_top_assertions_i (
  .clk(clk), .rst_n(rst_n), .sync_n(sync_n),
  .chip_reset_n(chip_reset_n), .power_down_pin_n(power_down_pin_n),
  .vco_cal_busy(vco_cal_busy), .drv_p(drv_p), .drv_n(drv_n),
  .drv_safe_pd(drv_safe_pd), .drv_total_pd(drv_total_pd),
  .align_active(align_active));

/* File: dv/oarc_top_bench.sv */
// Self-checking bench for oarc_top with a register model.
// Assumes shortened load counts; pins come from the host model.
`timescale 1ns/100ps
module oarc_top_bench;
  localparam int POR = 50;
  localparam int EE = 30;
  localparam int PIPE = 19;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic vco_cal_busy = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, sync_n, chip_reset_n, power_down_pin_n, cfg_sel;
  wire [11:0] drv_p, drv_n, drv_safe_pd, cmos_a, cmos_a_oe_n;
  wire [11:0] cmos_b, cmos_b_oe_n;
  wire [23:0] drv_swing;
  wire drv_total_pd, align_active;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] m [int];
  logic [31:0] rdat;
  logic rerr, prev;
  logic [7:0] d;
  oarc_top #(.POR_CYC(24'(POR)), .EE_CYC(24'(EE))) oarc_top_i (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_n(sync_n), .chip_reset_n(chip_reset_n),
    .power_down_pin_n(power_down_pin_n), .cfg_sel(cfg_sel),
    .vco_cal_busy(vco_cal_busy), .drv_p(drv_p), .drv_n(drv_n),
    .drv_swing(drv_swing), .drv_safe_pd(drv_safe_pd),
    .drv_total_pd(drv_total_pd), .cmos_a(cmos_a),
    .cmos_a_oe_n(cmos_a_oe_n), .cmos_b(cmos_b),
    .cmos_b_oe_n(cmos_b_oe_n), .align_active(align_active));
  oarc_host_pins oarc_host_pins_i (.clk(clk), .sync_n(sync_n),
    .chip_reset_n(chip_reset_n), .power_down_pin_n(power_down_pin_n),
    .cfg_sel(cfg_sel));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////
  task print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Ceiling is more than ten times the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int hi);
    if (n >= lo && n <= hi)
      chk(nm, n, n);
    else
      chk(nm, lo, n);
  endtask
  task tend(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  task apb(input logic [11:0] idx, input logic w, input logic [7:0] v);
    @(posedge clk);
    paddr <= {idx, 2'b00};
    pwrite <= w;
    pwdata <= {24'h000000, v};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] idx, input logic [7:0] v);
    logic [7:0] e;
    e = v;
    if (idx < 12'h100 && v[7] && !(m.exists(idx) && m[idx][7]))
      e[6:5] = 2'b11;
    m[idx] = e;
    apb(idx, 1'b1, v);
  endtask
  task rd(input logic [11:0] idx);
    apb(idx, 1'b0, 8'h00);
    chk($sformatf("reg_%h", idx), m.exists(idx) ? {24'h0, m[idx]} : 0,
      rdat);
  endtask
  // Counts edges until the hold starts, then until it ends
  task wait_idle();
    n = 0;
    while (align_active !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (align_active !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h4077));
    repeat (3) @(posedge clk);
    chk("rst_hold", 1, align_active);
    chk("rst_safe", 12'hFFF, drv_safe_pd);
    chk("rst_oe", 24'hFFFFFF, {cmos_a_oe_n, cmos_b_oe_n});
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle();
    chk_rng("por_release", POR, POR + 40);
    apb(12'h100, 1'b0, 8'h00);
    chk("unmapped_err", 1, rerr);
    chk("unmapped_data", 0, rdat);
    tend("power_on");
    wr(12'h191, 8'h10);
    wr(12'h197, 8'h20);
    oarc_host_pins_i.drive(0, 1'b0);
    repeat (8) @(posedge clk);
    chk("pin_hold", 1, align_active);
    chk("hold_ch0", 3'b111, drv_p[2:0]);
    chk("hold_ch1", 3'b000, drv_p[5:3]);
    n = 0;
    prev = drv_p[6];
    repeat (4) begin
      @(posedge clk);
      if (drv_p[6] !== prev)
        n++;
      prev = drv_p[6];
    end
    chk_rng("ignored_toggles", 2, 4);
    oarc_host_pins_i.drive(0, 1'b1);
    wait_idle();
    chk_rng("pin_latency", PIPE - 2, PIPE + 2);
    tend("sync_pin");
    apb(12'h230, 1'b1, 8'h01);
    repeat (6) @(posedge clk);
    chk("no_update_no_sync", 0, align_active);
    apb(12'h232, 1'b1, 8'h01);
    repeat (6) @(posedge clk);
    chk("soft_hold", 1, align_active);
    apb(12'h230, 1'b1, 8'h02);
    apb(12'h232, 1'b1, 8'h01);
    repeat (4) @(posedge clk);
    chk("total_pd", 1, drv_total_pd);
    chk("total_off", 0, drv_p | drv_n);
    apb(12'h230, 1'b1, 8'h00);
    apb(12'h232, 1'b1, 8'h01);
    wait_idle();
    chk_rng("soft_release", 10, 30);
    chk("total_pd_off", 0, drv_total_pd);
    tend("soft_sync");
    @(posedge clk);
    vco_cal_busy <= 1'b1;
    repeat (12) @(posedge clk);
    chk("vco_hold", 1, align_active);
    vco_cal_busy <= 1'b0;
    wait_idle();
    chk_rng("vco_release", 10, 30);
    oarc_host_pins_i.drive(2, 1'b0);
    repeat (8) @(posedge clk);
    chk("sleep_safe", 12'hFFF, drv_safe_pd);
    oarc_host_pins_i.drive(2, 1'b1);
    wait_idle();
    chk_rng("sleep_release", 10, 30);
    tend("vco_sleep");
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom) & 8'h07;
      wr(12'(12'h0F0 + i), d);
      rd(12'(12'h0F0 + i));
      repeat (2) @(posedge clk);
      chk("swing", d[2:1], drv_swing[2 * i +: 2]);
      chk("safe_pd", d[0], drv_safe_pd[i]);
    end
    wr(12'h0F1, 8'h80);
    rd(12'h0F1);
    repeat (2) @(posedge clk);
    chk("cmos_on", 2'b00, {cmos_b_oe_n[1], cmos_a_oe_n[1]});
    wr(12'h0F1, 8'hA0);
    repeat (2) @(posedge clk);
    chk("cmos_b_off", 2'b10, {cmos_b_oe_n[1], cmos_a_oe_n[1]});
    wr(12'h195, 8'h04);
    repeat (2) @(posedge clk);
    chk("chan_pd", 3'b111, drv_safe_pd[5:3]);
    tend("drivers");
    apb(12'h000, 1'b1, 8'h24);
    wait_idle();
    chk_rng("srst_done", 400, 440);
    m.delete();
    rd(12'h0F1);
    rd(12'h195);
    rd(12'h000);
    wr(12'h0F2, 8'h06);
    oarc_host_pins_i.pulse(1, 8);
    wait_idle();
    chk_rng("reset_release", 400, 440);
    m.delete();
    rd(12'h0F2);
    tend("resets");
    wr(12'h0F3, 8'h04);
    apb(12'hB02, 1'b1, 8'h02);
    repeat (8) @(posedge clk);
    chk("reload_ignored", 0, align_active);
    rd(12'h0F3);
    oarc_host_pins_i.drive(3, 1'b1);
    repeat (4) @(posedge clk);
    apb(12'hB02, 1'b1, 8'h02);
    wait_idle();
    chk_rng("reload_release", EE, EE + 40);
    m.delete();
    rd(12'h0F3);
    rd(12'hB02);
    tend("reload");
    print_verdict();
  end
endmodule
